/* File: fpec_regs.svh */
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH

// Register byte addresses on the APB
`define FPEC_ADDR_CCS      12'h000
`define FPEC_ADDR_PRS      12'h004
`define FPEC_ADDR_ERS      12'h008
`define FPEC_ADDR_KEY      12'h00C
`define FPEC_ADDR_TDA      12'h010

// Field positions
`define FPEC_CCS_ERR_BIT   4
`define FPEC_CCS_REQ_BIT   0
`define FPEC_SEL_BIT       0

// Reset values
`define FPEC_CCS_RSV7_INIT 1'b1
`define FPEC_SEL_INIT      1'b0
`define FPEC_ERR_INIT      1'b0
`define FPEC_KEY_INIT      8'h00
`define FPEC_TDA_INIT      8'h00

// Key codes
`define FPEC_KEY_DOWNLOAD  8'hA5
`define FPEC_KEY_PROGERASE 8'h5A

// Routine storage and download length
`define FPEC_PROG_SRC      16'h0000
`define FPEC_ERASE_SRC     16'h0100
`define FPEC_ROUTINE_LAST  16'h00FF

// Lengthened reset after an error: 100 us at 40 ns per cycle
`define FPEC_ERR_RST_CYCLES 2500

`endif

/* File: fpec_pkg.sv */
package fpec_pkg;

   // Download engine states
   typedef enum logic [1:0] {DL_IDLE, DL_FETCH, DL_COPY} fpec_dl_e;

   // Illegal events that the core reports while flash is busy
   typedef struct packed {
      logic irq;
      logic flashRead;
      logic sleep;
      logic otherMaster;
   } fpec_evt_s;

   // One byte write into on-chip RAM
   typedef struct packed {
      logic        en;
      logic [15:0] addr;
      logic [7:0]  data;
   } fpec_ramwr_s;

endpackage : fpec_pkg

/* File: fpec_dl_engine.sv */
`timescale 1ns/10ps
`include "fpec_regs.svh"

module fpec_dl_engine
   import fpec_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        abort,
   input  wire logic        start,
   input  wire logic [15:0] srcBase,
   input  wire logic [15:0] dstBase,
   input  wire logic [7:0]  romData,
   output logic      [15:0] romAddr,
   output fpec_ramwr_s      ramWr,
   output logic             busy,
   output logic             done
);

   fpec_dl_e    state_r;
   logic [15:0] idx_r;
   logic [15:0] src_r;
   logic [15:0] dst_r;
   logic [15:0] romAddr_r;
   fpec_ramwr_s ramWr_r;
   logic        done_r;
   logic        busy_r;

   // Copy loop: fetch a routine byte, then write it to RAM
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r   <= DL_IDLE;
         idx_r     <= 16'h0000;
         src_r     <= 16'h0000;
         dst_r     <= 16'h0000;
         romAddr_r <= 16'h0000;
         ramWr_r   <= '0;
         done_r    <= 1'b0;
         busy_r    <= 1'b0;
      end
      else
      begin
         ramWr_r.en <= 1'b0;
         done_r     <= 1'b0;
         if (abort)
         begin
            state_r <= DL_IDLE;
            busy_r  <= 1'b0;
         end
         else
         begin
            case (state_r)
               DL_IDLE:
               begin
                  if (start)
                  begin
                     src_r     <= srcBase;
                     dst_r     <= dstBase;
                     idx_r     <= 16'h0000;
                     romAddr_r <= srcBase;
                     busy_r    <= 1'b1;
                     state_r   <= DL_FETCH;
                  end
               end
               DL_FETCH:
                  state_r <= DL_COPY;
               DL_COPY:
               begin
                  ramWr_r.en   <= 1'b1; // RQ13
                  ramWr_r.addr <= dst_r + idx_r;
                  ramWr_r.data <= romData;
                  if (idx_r == `FPEC_ROUTINE_LAST)
                  begin
                     done_r  <= 1'b1;
                     busy_r  <= 1'b0;
                     state_r <= DL_IDLE;
                  end
                  else
                  begin
                     idx_r     <= idx_r + 16'h0001;
                     romAddr_r <= src_r + idx_r + 16'h0001;
                     state_r   <= DL_FETCH;
                  end
               end
               default:
               begin
                  state_r <= DL_IDLE;
                  busy_r  <= 1'b0;
               end
            endcase
         end
      end
   end

   assign romAddr = romAddr_r;
   assign ramWr   = ramWr_r;
   assign busy    = busy_r;
   assign done    = done_r;

   chk_copy_starts: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ13
      (start && !abort && state_r == DL_IDLE) |=> ##2 (ramWr_r.en && ramWr_r.addr == $past(dstBase, 3)))
      else $error("download did not write first byte to target");

endmodule : fpec_dl_engine

/* File: fpec_ctrl.sv */
// Summary of operation
// RQ1 - All interface registers are eight bits wide, reached by byte accesses.
// RQ2 - Power-on reset and both standby entries restore initial register values.
// RQ3 - Software standby leaves the flash error flag untouched.
// RQ4 - Control bit 7 reads 0; software writes 1; initial value 1.
// RQ5 - Other reserved bits read 0; software writes 0 to them.
// RQ6 - Error flag bit 4 starts 0; when set, programming and erasing blocked.
// RQ7 - Interrupt or NMI during programming or erasing sets the error flag.
// RQ8 - Flash array read during programming or erasing sets the error flag.
// RQ9 - Sleep instruction during programming or erasing sets the error flag.
// RQ10 - Another bus master taking the bus during programming sets the flag.
// RQ11 - Only power-on reset or hardware standby clears the error flag.
// RQ12 - After an error, reset must be held 100 us before release.
// RQ13 - Download request copies the selected routine into RAM at target address.
// RQ14 - Download request accepted only with key A5 and execution from RAM.
// RQ15 - Software runs four no-operations right after requesting a download.
// RQ16 - Download request clears when the copy completes; never reads as 1.
// RQ17 - System keeps interrupts disabled while a download is in progress.
// RQ18 - Program select bit 0 chooses programming routine; cleared when copy completes.
// RQ19 - Erase select bit 0 chooses erasing routine; cleared when copy completes.
// RQ20 - Programming or erasing is enabled only while the key holds 5A.
// RQ21 - Writes to the error flag and reserved bits change nothing.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "fpec_regs.svh"

module fpec_ctrl
   import fpec_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        hwStandby,
   input  wire logic        swStandby,
   input  wire logic        progEraseActive,
   input  wire logic        execFromRam,
   input  wire fpec_evt_s   errEvt,
   input  wire logic [7:0]  romData,
   output logic      [15:0] romAddr,
   output fpec_ramwr_s      ramWr,
   output logic             flashErrProtect,
   output logic             progEraseEnable,
   output logic             downloadBusy
);

   logic        hwSb1_r;
   logic        hwSb2_r;
   logic        stbyClr;
   logic        errFlag_r;
   logic        dlReq_r;
   logic        progSel_r;
   logic        eraseSel_r;
   logic [7:0]  key_r;
   logic [7:0]  tda_r;
   logic        peEnable_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        setupCyc;
   logic        wrAcc;
   logic        wrCcs;
   logic        wrPrs;
   logic        wrErs;
   logic        wrKey;
   logic        wrTda;
   logic        mapped;
   logic        errEvent;
   logic        dlAccept;
   logic        dlDone;
   logic [15:0] srcBase;
   logic [15:0] dstBase;

   // Hardware standby pin passes two flip-flops
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hwSb1_r <= 1'b0;
         hwSb2_r <= 1'b0;
      end
      else
      begin
         hwSb1_r <= hwStandby;
         hwSb2_r <= hwSb1_r;
      end
   end

   // Either standby returns the interface registers to initial values, except the error flag under software standby
   assign stbyClr = hwSb2_r | swStandby; // RQ2

   // APB decode; only the low byte lane carries register data
   assign setupCyc = psel & ~penable;
   assign wrAcc    = psel & penable & pready_r & pwrite & pstrb[0] & ~pslverr_r; // RQ1
   assign wrCcs    = wrAcc & (paddr == `FPEC_ADDR_CCS);
   assign wrPrs    = wrAcc & (paddr == `FPEC_ADDR_PRS);
   assign wrErs    = wrAcc & (paddr == `FPEC_ADDR_ERS);
   assign wrKey    = wrAcc & (paddr == `FPEC_ADDR_KEY);
   assign wrTda    = wrAcc & (paddr == `FPEC_ADDR_TDA);

   // Address map check
   always_comb
   begin
      case (paddr)
         `FPEC_ADDR_CCS,
         `FPEC_ADDR_PRS,
         `FPEC_ADDR_ERS,
         `FPEC_ADDR_KEY,
         `FPEC_ADDR_TDA: mapped = 1'b1;
         default:        mapped = 1'b0;
      endcase
   end

   // Ready and error answer during the access phase
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r  <= setupCyc;
         pslverr_r <= setupCyc & ~mapped;
      end
   end

   // Read data captured in the setup cycle; reserved bits read zero
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         prdata_r <= 32'h0000_0000;
      else if (setupCyc)
      begin
         prdata_r <= 32'h0000_0000; // RQ5
         if (!pwrite)
         begin
            case (paddr)
               `FPEC_ADDR_CCS: prdata_r[`FPEC_CCS_ERR_BIT] <= errFlag_r; // RQ4 RQ16
               `FPEC_ADDR_PRS: prdata_r[`FPEC_SEL_BIT]     <= progSel_r;
               `FPEC_ADDR_ERS: prdata_r[`FPEC_SEL_BIT]     <= eraseSel_r;
               `FPEC_ADDR_KEY: prdata_r[7:0]               <= key_r;
               `FPEC_ADDR_TDA: prdata_r[7:0]               <= tda_r;
               default:        prdata_r                    <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Illegal events only count while programming or erasing runs
   assign errEvent = progEraseActive &
                     (errEvt.irq | errEvt.flashRead | errEvt.sleep | errEvt.otherMaster); // RQ7 RQ8 RQ9 RQ10

   // Error flag: sticky, ignores writes and software standby
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         errFlag_r <= `FPEC_ERR_INIT;
      else if (hwSb2_r)
         errFlag_r <= `FPEC_ERR_INIT; // RQ11 RQ3
      else if (errEvent)
         errFlag_r <= 1'b1; // RQ6
   end

   // Key register
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         key_r <= `FPEC_KEY_INIT;
      else if (stbyClr)
         key_r <= `FPEC_KEY_INIT;
      else if (wrKey)
         key_r <= pwdata[7:0];
   end

   // Download target address register
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         tda_r <= `FPEC_TDA_INIT;
      else if (stbyClr)
         tda_r <= `FPEC_TDA_INIT;
      else if (wrTda)
         tda_r <= pwdata[7:0];
   end

   // Download request needs the key, execution from RAM and a selected routine
   assign dlAccept  = wrCcs & pwdata[`FPEC_CCS_REQ_BIT] & (key_r == `FPEC_KEY_DOWNLOAD) &
                      execFromRam & ~dlReq_r & (progSel_r | eraseSel_r); // RQ14
   assign srcBase   = progSel_r ? `FPEC_PROG_SRC : `FPEC_ERASE_SRC;
   assign dstBase   = {tda_r, 8'h00};

   // Download request bit, cleared by completion
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         dlReq_r <= 1'b0;
      else if (stbyClr)
         dlReq_r <= 1'b0;
      else if (dlAccept)
         dlReq_r <= 1'b1;
      else if (dlDone)
         dlReq_r <= 1'b0; // RQ16
   end

   // Programming routine select; a write wins over completion
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         progSel_r <= `FPEC_SEL_INIT;
      else if (stbyClr)
         progSel_r <= `FPEC_SEL_INIT;
      else if (wrPrs)
         progSel_r <= pwdata[`FPEC_SEL_BIT]; // RQ21
      else if (dlDone)
         progSel_r <= 1'b0; // RQ18
   end

   // Erasing routine select; a write wins over completion
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         eraseSel_r <= `FPEC_SEL_INIT;
      else if (stbyClr)
         eraseSel_r <= `FPEC_SEL_INIT;
      else if (wrErs)
         eraseSel_r <= pwdata[`FPEC_SEL_BIT];
      else if (dlDone)
         eraseSel_r <= 1'b0; // RQ19
   end

   // Flash may be programmed or erased only with the right key and no error
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         peEnable_r <= 1'b0;
      else
         peEnable_r <= (key_r == `FPEC_KEY_PROGERASE) & ~errFlag_r & ~hwSb2_r; // RQ20 RQ6
   end

   // Routine copy engine
   fpec_dl_engine u_dl_engine (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .abort   (stbyClr),
      .start   (dlAccept),
      .srcBase (srcBase),
      .dstBase (dstBase),
      .romData (romData),
      .romAddr (romAddr),
      .ramWr   (ramWr),
      .busy    (downloadBusy),
      .done    (dlDone)
   );

   assign prdata          = prdata_r;
   assign pready          = pready_r;
   assign pslverr         = pslverr_r;
   assign flashErrProtect = errFlag_r;
   assign progEraseEnable = peEnable_r;

   // Checks on the control and program select register read images
   chk_ccs_read_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ4
      (setupCyc && !pwrite && paddr == `FPEC_ADDR_CCS) |=>
         (prdata_r[7:5] == 3'b000 && prdata_r[3:0] == 4'h0 && prdata_r[4] == $past(errFlag_r)))
      else $error("control register read image wrong");

   chk_sel_read_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ5
      (setupCyc && !pwrite && paddr == `FPEC_ADDR_PRS) |=>
         (prdata_r[31:1] == 31'h0 && prdata_r[0] == $past(progSel_r)))
      else $error("select register read image wrong");

   // Checks on the error flag
   chk_err_irq_set: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ7
      (progEraseActive && errEvt.irq && !hwSb2_r) |=> (errFlag_r && flashErrProtect))
      else $error("interrupt during flash work did not set error");

   chk_err_read_set: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ8
      (progEraseActive && errEvt.flashRead && !hwSb2_r) |=> errFlag_r)
      else $error("flash read during flash work did not set error");

   chk_err_sleep_set: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ9
      (progEraseActive && errEvt.sleep && !hwSb2_r) |=> errFlag_r)
      else $error("sleep during flash work did not set error");

   chk_err_master_set: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ10
      (progEraseActive && errEvt.otherMaster && !hwSb2_r) |=> errFlag_r)
      else $error("other bus master did not set error");

   chk_err_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ11
      (errFlag_r && !hwSb2_r) |=> errFlag_r)
      else $error("error flag cleared without hardware standby");

   chk_err_no_event: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ21
      (!errFlag_r && !errEvent) |=> !errFlag_r)
      else $error("error flag set without an event");

   chk_err_block_pe: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ6
      errFlag_r |=> !progEraseEnable)
      else $error("flash left enabled under error");

   // Checks on standby, key and download flow
   chk_sw_standby_init: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ2
      swStandby |=> (key_r == 8'h00 && tda_r == 8'h00 && !progSel_r && !eraseSel_r && !dlReq_r))
      else $error("software standby did not restore registers");

   chk_req_needs_key: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ14
      $rose(dlReq_r) |-> ($past(key_r) == 8'hA5 && $past(execFromRam) && $past(wrCcs)))
      else $error("download accepted without key or RAM execution");

   chk_pe_key: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ20
      progEraseEnable |-> ($past(key_r) == 8'h5A && !$past(errFlag_r)))
      else $error("flash enabled without program key");

   chk_dl_clears: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ18
      (dlDone && !stbyClr && !wrPrs) |=> (!dlReq_r && !progSel_r))
      else $error("download completion did not clear request and select");

   chk_req_busy: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ13
      (dlAccept && !stbyClr) |=> (downloadBusy && dlReq_r))
      else $error("download request did not start the copy");

   chk_ers_clears: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ19
      (dlDone && !stbyClr && !wrErs) |=> !eraseSel_r)
      else $error("download completion did not clear erase select");

   // Checks on software standby and byte strobe
   chk_sw_keeps_err: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ3
      (swStandby && !hwSb2_r && !errEvent) |=> (errFlag_r == $past(errFlag_r)))
      else $error("software standby changed the error flag");

   chk_strobe_ignored: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ1
      (psel && penable && pready_r && pwrite && !pstrb[0] && paddr == `FPEC_ADDR_KEY && !stbyClr) |=> $stable(key_r))
      else $error("write without low byte strobe changed the key");

endmodule : fpec_ctrl

/* File: fpec_rom_model.sv */
`timescale 1ns/10ps

module fpec_rom_model
   import fpec_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic [15:0] romAddr,
   output logic      [7:0]  romData
);

   // Routine storage answers one cycle after the address, with a pattern that differs per byte and routine
   always_ff @(posedge clk_sys)
   begin
      romData <= romAddr[7:0] ^ {romAddr[8], 7'h35};
   end

endmodule : fpec_rom_model

/* File: fpec_ctrl_tb_top.sv */
`timescale 1ns/10ps
`include "fpec_regs.svh"

module fpec_ctrl_tb_top
   import fpec_pkg::*;
;

   logic        clk_sys;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        hwStandby;
   logic        swStandby;
   logic        progEraseActive;
   logic        execFromRam;
   fpec_evt_s   errEvt;
   logic [7:0]  romData;
   logic [15:0] romAddr;
   fpec_ramwr_s ramWr;
   logic        flashErrProtect;
   logic        progEraseEnable;
   logic        downloadBusy;
   logic [31:0] rdData;
   logic        rdErr;
   int          failures;
   int          totalChecks;
   int          cycleCount;

   // Clock at 25 MHz
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   fpec_ctrl fpec_ctrl_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hwStandby(hwStandby), .swStandby(swStandby), .progEraseActive(progEraseActive),
      .execFromRam(execFromRam), .errEvt(errEvt), .romData(romData), .romAddr(romAddr), .ramWr(ramWr),
      .flashErrProtect(flashErrProtect), .progEraseEnable(progEraseEnable), .downloadBusy(downloadBusy)
   );

   fpec_rom_model fpec_rom_model_inst (
      .clk_sys(clk_sys), .romAddr(romAddr), .romData(romData)
   );

   // Verdict and end of run
   task automatic end_sim();
      begin
         $display("Checks %0d, mismatches %0d", totalChecks, failures);
         if (failures == 0 && totalChecks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask : end_sim

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
      begin
         totalChecks++;
         if (seen !== expected)
         begin
            failures++;
            $display("FAIL %0t %s seen %h expected %h", $time, what, seen, expected);
         end
      end
   endtask : check

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] data);
      begin
         @(posedge clk_sys);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= wr;
         paddr   <= addr;
         pwdata  <= {24'h000000, data};
         @(posedge clk_sys);
         penable <= 1'b1;
         do
            @(posedge clk_sys);
         while (pready !== 1'b1);
         rdData = prdata;
         rdErr = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic wr(input logic [11:0] addr, input logic [7:0] data);
      apb(1'b1, addr, data);
   endtask : wr

   task automatic rd_chk(input logic [11:0] addr, input logic [31:0] expected, input string what);
      begin
         apb(1'b0, addr, 8'h00);
         check(rdData, expected, what);
      end
   endtask : rd_chk

   // Register values after power-on reset and an unmapped access
   task automatic test_reset_values();
      begin
         rd_chk(`FPEC_ADDR_CCS, 32'h00000000, "control after reset");
         rd_chk(`FPEC_ADDR_PRS, 32'h00000000, "program select after reset");
         rd_chk(`FPEC_ADDR_ERS, 32'h00000000, "erase select after reset");
         rd_chk(`FPEC_ADDR_KEY, 32'h00000000, "key after reset");
         rd_chk(`FPEC_ADDR_TDA, 32'h00000000, "target after reset");
         apb(1'b0, 12'h040, 8'h00);
         check(rdErr, 1'b1, "unmapped read error");
         check(flashErrProtect, 1'b0, "error flag after reset");
      end
   endtask : test_reset_values

   // Reserved and read-only bits, byte lane and strobe handling
   task automatic test_reserved_bits();
      begin
         wr(`FPEC_ADDR_CCS, 8'hFE);
         rd_chk(`FPEC_ADDR_CCS, 32'h00000000, "control reserved");
         wr(`FPEC_ADDR_PRS, 8'hFF);
         rd_chk(`FPEC_ADDR_PRS, 32'h00000001, "program select reserved");
         wr(`FPEC_ADDR_PRS, 8'h00);
         wr(`FPEC_ADDR_KEY, 8'hC3);
         rd_chk(`FPEC_ADDR_KEY, 32'h000000C3, "key byte");
         pstrb <= 4'h0;
         wr(`FPEC_ADDR_KEY, 8'h00);
         pstrb <= 4'hF;
         rd_chk(`FPEC_ADDR_KEY, 32'h000000C3, "strobe off write");
         wr(`FPEC_ADDR_KEY, 8'h00);
      end
   endtask : test_reserved_bits

   // Download request refused without the key or outside RAM
   task automatic test_refused_download();
      begin
         wr(`FPEC_ADDR_PRS, 8'h01);
         for (int k = 0; k < 2; k++)
         begin
            execFromRam <= (k == 1) ? 1'b0 : 1'b1;
            wr(`FPEC_ADDR_KEY, (k == 1) ? `FPEC_KEY_DOWNLOAD : `FPEC_KEY_PROGERASE);
            wr(`FPEC_ADDR_CCS, 8'h81);
            repeat (4) @(posedge clk_sys);
            check(downloadBusy, 1'b0, "refused request");
            rd_chk(`FPEC_ADDR_PRS, 32'h00000001, "select kept");
         end
         wr(`FPEC_ADDR_PRS, 8'h00);
         execFromRam <= 1'b1;
      end
   endtask : test_refused_download

   // Full routine download, checked byte by byte; interrupts stay quiet meanwhile
   task automatic run_download(input logic [11:0] selAddr, input logic [15:0] src, input logic [7:0] tda);
      int          i;
      int          n;
      logic [15:0] dst;
      begin
         wr(`FPEC_ADDR_TDA, tda);
         wr(selAddr, 8'h01);
         wr(`FPEC_ADDR_KEY, `FPEC_KEY_DOWNLOAD);
         wr(`FPEC_ADDR_CCS, 8'h81);
         @(posedge clk_sys);
         check(downloadBusy, 1'b1, "download started");
         i = 0;
         n = 0;
         while (i < 256 && n < 800)
         begin
            @(posedge clk_sys);
            n++;
            if (ramWr.en === 1'b1)
            begin
               dst = {tda, 8'h00} + 16'(i);
               check({ramWr.addr, ramWr.data}, {8'h00, dst, src[7:0] ^ 8'(i) ^ {src[8], 7'h35}}, "ram byte");
               i++;
            end
         end
         check(32'(i), 32'd256, "byte count");
         repeat (3) @(posedge clk_sys);
         check(downloadBusy, 1'b0, "download ended");
         rd_chk(selAddr, 32'h00000000, "select cleared");
         rd_chk(`FPEC_ADDR_CCS, 32'h00000000, "request cleared");
      end
   endtask : run_download

   task automatic test_program_download();
      run_download(`FPEC_ADDR_PRS, `FPEC_PROG_SRC, 8'h20);
   endtask : test_program_download

   task automatic test_erase_download();
      run_download(`FPEC_ADDR_ERS, `FPEC_ERASE_SRC, 8'hF1);
   endtask : test_erase_download

   // Each illegal event sets the flag; software standby keeps it, hardware standby clears it
   task automatic test_error_flag();
      begin
         errEvt <= 4'hF;
         @(posedge clk_sys);
         errEvt <= 4'h0;
         repeat (2) @(posedge clk_sys);
         check(flashErrProtect, 1'b0, "event while idle");
         for (int b = 0; b < 4; b++)
         begin
            wr(`FPEC_ADDR_KEY, `FPEC_KEY_PROGERASE);
            repeat (2) @(posedge clk_sys);
            check(progEraseEnable, 1'b1, "key enables");
            progEraseActive <= 1'b1;
            errEvt <= fpec_evt_s'(4'(1 << b));
            @(posedge clk_sys);
            errEvt <= 4'h0;
            progEraseActive <= 1'b0;
            repeat (2) @(posedge clk_sys);
            check(flashErrProtect, 1'b1, "event sets flag");
            check(progEraseEnable, 1'b0, "protection blocks");
            wr(`FPEC_ADDR_CCS, 8'h80);
            rd_chk(`FPEC_ADDR_CCS, 32'h00000010, "flag read");
            swStandby <= 1'b1;
            repeat (2) @(posedge clk_sys);
            swStandby <= 1'b0;
            repeat (2) @(posedge clk_sys);
            check(flashErrProtect, 1'b1, "kept in soft standby");
            rd_chk(`FPEC_ADDR_KEY, 32'h00000000, "key cleared in standby");
            hwStandby <= 1'b1;
            repeat (6) @(posedge clk_sys);
            hwStandby <= 1'b0;
            repeat (4) @(posedge clk_sys);
            check(flashErrProtect, 1'b0, "cleared in hard standby");
         end
      end
   endtask : test_error_flag

   // Error, then a power-on reset held for the lengthened period
   task automatic test_error_reset();
      begin
         progEraseActive <= 1'b1;
         errEvt <= 4'h8;
         @(posedge clk_sys);
         progEraseActive <= 1'b0;
         errEvt <= 4'h0;
         wr(`FPEC_ADDR_KEY, `FPEC_KEY_DOWNLOAD);
         check(flashErrProtect, 1'b1, "flag before reset");
         sys_rst <= 1'b1;
         repeat (`FPEC_ERR_RST_CYCLES) @(posedge clk_sys);
         sys_rst <= 1'b0;
         check(flashErrProtect, 1'b0, "flag after power-on reset");
         rd_chk(`FPEC_ADDR_KEY, 32'h00000000, "key after power-on reset");
         rd_chk(`FPEC_ADDR_CCS, 32'h00000000, "control after power-on reset");
      end
   endtask : test_error_reset

   // Hang guard
   always @(posedge clk_sys)
   begin
      cycleCount++;
      if (cycleCount >= 8000)
      begin
         failures++;
         end_sim();
      end
   end

   // Main sequence
   initial
   begin
      failures = 0;
      totalChecks = 0;
      cycleCount = 0;
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      hwStandby = 1'b0;
      swStandby = 1'b0;
      progEraseActive = 1'b0;
      execFromRam = 1'b1;
      errEvt = 4'h0;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      test_reset_values();
      test_reserved_bits();
      test_refused_download();
      test_program_download();
      test_erase_download();
      test_error_flag();
      test_error_reset();
      end_sim();
   end

endmodule : fpec_ctrl_tb_top
